// File: rtcia_pkg.sv
package rtcia_pkg;
    // I/O addresses of the two ports that front the clock
    localparam logic [15:0] IO_INDEX_ADDR = 16'h0070;
    localparam logic [15:0] IO_DATA_ADDR = 16'h0071;
    // Indexed register numbers
    localparam logic [6:0] IDX_SEC = 7'h00;
    localparam logic [6:0] IDX_ALM_SEC = 7'h01;
    localparam logic [6:0] IDX_MIN = 7'h02;
    localparam logic [6:0] IDX_ALM_MIN = 7'h03;
    localparam logic [6:0] IDX_HOUR = 7'h04;
    localparam logic [6:0] IDX_ALM_HOUR = 7'h05;
    localparam logic [6:0] IDX_WDAY = 7'h06;
    localparam logic [6:0] IDX_MDAY = 7'h07;
    localparam logic [6:0] IDX_MONTH = 7'h08;
    localparam logic [6:0] IDX_YEAR = 7'h09;
    localparam logic [6:0] IDX_CTRL_A = 7'h0a;
    localparam logic [6:0] IDX_CTRL_B = 7'h0b;
    localparam logic [6:0] IDX_FLAGS = 7'h0c;
    localparam logic [6:0] IDX_VALID = 7'h0d;
    // Field positions of divider_rate_control
    localparam int A_UIP = 7;
    localparam logic [2:0] A_DIV_RUN = 3'h2;
    // Field positions of interrupt_format_control
    localparam int B_INHIBIT = 7;
    localparam int B_BINARY = 2;
    localparam int B_HOUR24 = 1;
    localparam int B_DST = 0;
    // Field positions of event_flags and validity_alarm_day
    localparam int C_IRQ = 7;
    localparam int D_VALID = 7;
    // Reset values: divider running, periodic off, BCD, 24 hour
    localparam logic [7:0] A_RESET = 8'h20;
    localparam logic [7:0] B_RESET = 8'h02;
    // Time base
    localparam int unsigned CORE_HZ = 50_000_000;
    localparam int unsigned BASE_HZ = 32_768;
    localparam int unsigned BASE_CYCLES = CORE_HZ / BASE_HZ;
    localparam int unsigned SEC_TICKS = 32_768;
    localparam int unsigned UIP_LEAD_TICKS = 8;
    // Host register offsets on APB
    localparam logic [11:0] HOST_INDEX_OFF = 12'h000;
    localparam logic [11:0] HOST_DATA_OFF = 12'h004;
    localparam logic [11:0] HOST_STAT_OFF = 12'h008;
    localparam logic [11:0] HOST_CTRL_OFF = 12'h00c;
endpackage : rtcia_pkg

// File: rtcia_if.sv
`timescale 1ns/10ps
`default_nettype none
// Port-mapped I/O cycle between host and clock, plus the interrupt line
interface rtcia_if;
    logic [15:0] io_addr; // I/O address of the cycle
    logic io_stb; // One-cycle strobe per I/O cycle
    logic io_we; // High for a write
    logic [7:0] io_wdata; // Write byte
    logic [7:0] io_rdata; // Read byte, valid the cycle after the strobe
    logic irq; // Interrupt request level
    modport dev (input io_addr, input io_stb, input io_we, input io_wdata,
                 output io_rdata, output irq);
    modport host (output io_addr, output io_stb, output io_we, output io_wdata,
                  input io_rdata, input irq);
endinterface : rtcia_if
`default_nettype wire

// File: rtcia_tick.sv
`timescale 1ns/10ps
`default_nettype none
// Time base: 32.768 kHz ticks from the core clock, then the seconds divider
module rtcia_tick #(
    parameter int unsigned BASE_CYCLES = rtcia_pkg::BASE_CYCLES,
    parameter int unsigned SEC_TICKS = rtcia_pkg::SEC_TICKS,
    parameter int unsigned UIP_LEAD = rtcia_pkg::UIP_LEAD_TICKS
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic [3:0] rate,
    output logic uip_lead,
    output logic sec_pulse,
    output logic periodic
);
    typedef struct packed {
        logic [15:0] pre; // Core cycles inside one base tick
        logic [15:0] div; // Base ticks inside one second
    } rtcia_tick_st_t;

    rtcia_tick_st_t st_q;
    rtcia_tick_st_t st_d;
    logic base;
    logic [15:0] mask;

    // Rate n gives a period of 2^(n-1) base ticks; zero turns it off
    assign base = run && (st_q.pre == 16'(BASE_CYCLES - 1));
    assign mask = 16'((32'd1 << (rate - 4'd1)) - 32'd1);
    assign sec_pulse = base && (st_q.div == 16'(SEC_TICKS - 1));
    assign uip_lead = base && (st_q.div == 16'(SEC_TICKS - 1 - UIP_LEAD));
    assign periodic = base && (rate != 4'h0) && ((st_q.div & mask) == 16'h0000);

    // Divider held cleared unless the select field is the running code
    always_comb begin
        st_d = st_q;
        if (!run) begin
            st_d = '0;
        end else begin
            st_d.pre = base ? 16'h0000 : st_q.pre + 16'h0001;
            if (base) begin
                st_d.div = sec_pulse ? 16'h0000 : st_q.div + 16'h0001;
            end
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule : rtcia_tick
`default_nettype wire

// File: rtcia_dev.sv
`timescale 1ns/10ps
`default_nettype none
module rtcia_dev #(
    parameter int unsigned SEC_TICKS = rtcia_pkg::SEC_TICKS,
    parameter int unsigned BASE_CYCLES = rtcia_pkg::BASE_CYCLES
) (
    input wire logic core_clk,
    input wire logic resetn,
    rtcia_if.dev bus
);
    typedef struct packed {
        logic [127:0][7:0] mem; // Whole indexed space, time and storage alike
        logic [6:0] index; // Selected register number
        logic [7:0] rdata; // Byte returned by the last read cycle
        logic uip; // Update in progress
        logic dst_done; // Autumn fall-back already applied today
    } rtcia_dev_st_t;

    rtcia_dev_st_t st_q;
    rtcia_dev_st_t st_d;
    logic uip_lead; // Base tick a few ticks ahead of the update
    logic sec_pulse; // Once-per-second update moment
    logic per_pulse; // Periodic event
    logic [7:0] ra; // Register A
    logic [7:0] rb; // Register B
    logic bin; // Binary data mode
    logic [7:0] s, m, h, h12, wd, md, mo, yr, dim; // Current time in binary
    logic [7:0] s_n, m_n, h_n, h12_n, wd_n, md_n, mo_n, yr_n, hr_enc; // Next time
    logic [7:0] h12_e, md_e; // Encoded next 12-hour value and day, kept apart for field selects
    logic c_min, c_hr, c_day, c_mon, c_yr, dst_fwd, dst_back, a_hit;
    logic [2:0] ev; // Periodic, alarm, update events this cycle
    logic [7:0] view; // Read view of the selected register

    // BCD or binary byte to plain binary
    function automatic logic [7:0] rtcia_dec(input logic [7:0] v, input logic b);
        rtcia_dec = b ? v : 8'({4'h0, v[7:4]} * 8'd10 + {4'h0, v[3:0]});
    endfunction : rtcia_dec

    // Plain binary to BCD or binary byte
    function automatic logic [7:0] rtcia_enc(input logic [7:0] n, input logic b);
        rtcia_enc = b ? n : {4'(n / 8'd10), 4'(n % 8'd10)};
    endfunction : rtcia_enc

    assign ra = st_q.mem[rtcia_pkg::IDX_CTRL_A];
    assign rb = st_q.mem[rtcia_pkg::IDX_CTRL_B];
    assign bin = rb[rtcia_pkg::B_BINARY];

    // Seconds divider; only runs on the documented select code
    rtcia_tick #(
        .BASE_CYCLES(BASE_CYCLES),
        .SEC_TICKS(SEC_TICKS),
        .UIP_LEAD(rtcia_pkg::UIP_LEAD_TICKS)
    ) u_tick (
        .core_clk(core_clk),
        .resetn(resetn),
        .run(ra[6:4] == rtcia_pkg::A_DIV_RUN),
        .rate(ra[3:0]),
        .uip_lead(uip_lead),
        .sec_pulse(sec_pulse),
        .periodic(per_pulse)
    );

    // Decode stored time; the hour is brought to a 0-23 value either way
    assign s = rtcia_dec(st_q.mem[rtcia_pkg::IDX_SEC], bin);
    assign m = rtcia_dec(st_q.mem[rtcia_pkg::IDX_MIN], bin);
    assign h12 = rtcia_dec({1'b0, st_q.mem[rtcia_pkg::IDX_HOUR][6:0]}, bin);
    assign h = rb[rtcia_pkg::B_HOUR24] ? rtcia_dec(st_q.mem[rtcia_pkg::IDX_HOUR], bin)
             : 8'((h12 == 8'd12 ? 8'd0 : h12)
                  + (st_q.mem[rtcia_pkg::IDX_HOUR][7] ? 8'd12 : 8'd0));
    assign wd = rtcia_dec(st_q.mem[rtcia_pkg::IDX_WDAY], bin);
    assign md = rtcia_dec(st_q.mem[rtcia_pkg::IDX_MDAY], bin);
    assign mo = rtcia_dec(st_q.mem[rtcia_pkg::IDX_MONTH], bin);
    assign yr = rtcia_dec(st_q.mem[rtcia_pkg::IDX_YEAR], bin);

    // Month length; two-digit year, so every fourth year is a leap year
    always_comb begin
        case (mo)
            8'd4, 8'd6, 8'd9, 8'd11: dim = 8'd30;
            8'd2: dim = (yr[1:0] == 2'b00) ? 8'd29 : 8'd28;
            default: dim = 8'd31;
        endcase
    end

    // Carry chain of one second's advance
    assign c_min = (s >= 8'd59);
    assign s_n = c_min ? 8'd0 : s + 8'd1;
    assign c_hr = c_min && (m >= 8'd59);
    assign m_n = c_min ? (c_hr ? 8'd0 : m + 8'd1) : m;
    // Daylight saving: first Sunday of April jumps 2 AM, last of October repeats 1 AM
    assign dst_fwd = rb[rtcia_pkg::B_DST] && c_hr && h == 8'd1 && wd == 8'd1
                     && mo == 8'd4 && md <= 8'd7;
    assign dst_back = rb[rtcia_pkg::B_DST] && c_hr && h == 8'd1 && wd == 8'd1
                      && mo == 8'd10 && md >= 8'd25 && !st_q.dst_done;
    assign c_day = c_hr && (h >= 8'd23);
    assign h_n = !c_hr ? h : dst_fwd ? 8'd3 : dst_back ? 8'd1 : c_day ? 8'd0 : h + 8'd1;
    assign h12_n = (h_n == 8'd0) ? 8'd12 : (h_n > 8'd12) ? h_n - 8'd12 : h_n;
    assign h12_e = rtcia_enc(h12_n, bin);
    assign hr_enc = rb[rtcia_pkg::B_HOUR24] ? rtcia_enc(h_n, bin)
                  : {h_n >= 8'd12, h12_e[6:0]};
    assign wd_n = c_day ? (wd >= 8'd7 ? 8'd1 : wd + 8'd1) : wd;
    assign c_mon = c_day && (md >= dim);
    assign md_n = c_day ? (c_mon ? 8'd1 : md + 8'd1) : md;
    assign c_yr = c_mon && (mo >= 8'd12);
    assign mo_n = c_mon ? (c_yr ? 8'd1 : mo + 8'd1) : mo;
    assign yr_n = c_yr ? (yr >= 8'd99 ? 8'd0 : yr + 8'd1) : yr;

    // Alarm against the new time; 11xxxxxx in a field or day 0 matches anything
    assign md_e = rtcia_enc(md_n, bin);
    assign a_hit = (st_q.mem[rtcia_pkg::IDX_ALM_SEC][7:6] == 2'b11
                    || st_q.mem[rtcia_pkg::IDX_ALM_SEC] == rtcia_enc(s_n, bin))
                && (st_q.mem[rtcia_pkg::IDX_ALM_MIN][7:6] == 2'b11
                    || st_q.mem[rtcia_pkg::IDX_ALM_MIN] == rtcia_enc(m_n, bin))
                && (st_q.mem[rtcia_pkg::IDX_ALM_HOUR][7:6] == 2'b11
                    || st_q.mem[rtcia_pkg::IDX_ALM_HOUR] == hr_enc)
                && (st_q.mem[rtcia_pkg::IDX_VALID][5:0] == 6'h00
                    || st_q.mem[rtcia_pkg::IDX_VALID][5:0] == md_e[5:0]);

    // Read view: status bits are built, not stored
    always_comb begin
        case (st_q.index)
            rtcia_pkg::IDX_CTRL_A: view = {st_q.uip, ra[6:0]};
            rtcia_pkg::IDX_FLAGS: view = {st_q.mem[rtcia_pkg::IDX_FLAGS][7:4], 4'h0};
            rtcia_pkg::IDX_VALID: view = {1'b1, 1'b0, st_q.mem[rtcia_pkg::IDX_VALID][5:0]};
            default: view = st_q.mem[st_q.index];
        endcase
    end

    // Next state: update timing, then the I/O cycle, then event flags
    always_comb begin
        st_d = st_q;
        ev = {per_pulse, 2'b00};
        // Busy rises ahead of the update so a low reading is safe
        if (uip_lead && !rb[rtcia_pkg::B_INHIBIT]) begin
            st_d.uip = 1'b1;
        end
        if (sec_pulse) begin
            // Busy falls on the same edge that loads the new time
            st_d.uip = 1'b0;
            if (!rb[rtcia_pkg::B_INHIBIT]) begin
                st_d.mem[rtcia_pkg::IDX_SEC] = rtcia_enc(s_n, bin);
                st_d.mem[rtcia_pkg::IDX_MIN] = rtcia_enc(m_n, bin);
                st_d.mem[rtcia_pkg::IDX_HOUR] = hr_enc;
                st_d.mem[rtcia_pkg::IDX_WDAY] = rtcia_enc(wd_n, bin);
                st_d.mem[rtcia_pkg::IDX_MDAY] = rtcia_enc(md_n, bin);
                st_d.mem[rtcia_pkg::IDX_MONTH] = rtcia_enc(mo_n, bin);
                st_d.mem[rtcia_pkg::IDX_YEAR] = rtcia_enc(yr_n, bin);
                st_d.dst_done = dst_back ? 1'b1 : (c_day ? 1'b0 : st_q.dst_done);
                ev[0] = 1'b1;
                ev[1] = a_hit;
            end
        end
        // I/O cycle; a write on the same edge as an update wins
        if (bus.io_stb) begin
            if (bus.io_addr == rtcia_pkg::IO_INDEX_ADDR && bus.io_we) begin
                st_d.index = bus.io_wdata[6:0];
            end else if (bus.io_addr == rtcia_pkg::IO_INDEX_ADDR) begin
                st_d.rdata = {1'b0, st_q.index};
            end else if (bus.io_addr == rtcia_pkg::IO_DATA_ADDR && bus.io_we) begin
                case (st_q.index)
                    rtcia_pkg::IDX_CTRL_A: st_d.mem[st_q.index] = {1'b0, bus.io_wdata[6:0]};
                    rtcia_pkg::IDX_FLAGS: st_d.mem[st_q.index] = st_q.mem[st_q.index];
                    rtcia_pkg::IDX_VALID: st_d.mem[st_q.index] = {2'b00, bus.io_wdata[5:0]};
                    // Square wave enable is stored but drives nothing
                    default: st_d.mem[st_q.index] = bus.io_wdata;
                endcase
            end else if (bus.io_addr == rtcia_pkg::IO_DATA_ADDR) begin
                st_d.rdata = view;
                if (st_q.index == rtcia_pkg::IDX_FLAGS) begin
                    st_d.mem[rtcia_pkg::IDX_FLAGS] = 8'h00;
                end
            end else if (!bus.io_we) begin
                // Other addresses float high on a read
                st_d.rdata = 8'hff;
            end
        end
        // Events are set after the read clear, so a colliding event survives
        st_d.mem[rtcia_pkg::IDX_FLAGS][6:4] = st_d.mem[rtcia_pkg::IDX_FLAGS][6:4] | ev;
        if (|(ev & rb[6:4])) begin
            st_d.mem[rtcia_pkg::IDX_FLAGS][rtcia_pkg::C_IRQ] = 1'b1;
        end
    end

    // State register; time registers come up zero, storage cleared
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
            st_q.mem[rtcia_pkg::IDX_CTRL_A] <= rtcia_pkg::A_RESET;
            st_q.mem[rtcia_pkg::IDX_CTRL_B] <= rtcia_pkg::B_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign bus.io_rdata = st_q.rdata;
    assign bus.irq = st_q.mem[rtcia_pkg::IDX_FLAGS][rtcia_pkg::C_IRQ];
endmodule : rtcia_dev
`default_nettype wire

// File: rtcia_host.sv
`timescale 1ns/10ps
`default_nettype none
// Host end: APB registers turned into index and data port cycles
module rtcia_host (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq_out,
    rtcia_if.host bus
);
    typedef enum logic [7:0] {
        HS_IDLE = 8'h01, // Waiting for an APB access
        HS_PIDX = 8'h02, // Index cycle pointing at register A
        HS_PRD = 8'h04, // Data read of register A
        HS_PCHK = 8'h08, // Look at the busy bit
        HS_IDX = 8'h10, // Index cycle for the target
        HS_DAT = 8'h20, // Data cycle for the target
        HS_CAP = 8'h40, // Capture read byte
        HS_DONE = 8'h80 // Answer the APB access
    } rtcia_hs_t;

    typedef struct packed {
        rtcia_hs_t state;
        logic [6:0] index; // Shadow of the last index written
        logic is_data; // Access goes on to the data port
        logic wr; // Data access is a write
        logic [7:0] data; // Data byte to write
        logic allow; // Software permits writes to unlisted registers
        logic err; // Access refused
        logic [31:0] prdata;
        logic stb;
        logic [15:0] addr;
        logic we;
        logic [7:0] wdata;
    } rtcia_host_st_t;

    rtcia_host_st_t st_q;
    rtcia_host_st_t st_d;
    logic listed; // Shadow index is one of the documented registers
    logic [7:0] wbyte; // Data byte with the divider field forced

    assign listed = (st_q.index <= rtcia_pkg::IDX_VALID)
                    && (st_q.index != rtcia_pkg::IDX_ALM_SEC)
                    && (st_q.index != rtcia_pkg::IDX_ALM_MIN)
                    && (st_q.index != rtcia_pkg::IDX_ALM_HOUR);
    assign wbyte = (st_q.index == rtcia_pkg::IDX_CTRL_A)
                   ? {pwdata[7], rtcia_pkg::A_DIV_RUN, pwdata[3:0]} : pwdata[7:0];

    // Sequencer; each step issues at most one I/O strobe
    always_comb begin
        st_d = st_q;
        st_d.stb = 1'b0;
        case (st_q.state)
            HS_IDLE: begin
                if (psel && penable) begin
                    st_d.err = 1'b0;
                    st_d.state = HS_DONE;
                    case (paddr)
                        rtcia_pkg::HOST_INDEX_OFF: begin
                            if (pwrite) begin
                                st_d.index = pwdata[6:0];
                                st_d.is_data = 1'b0;
                                st_d.state = HS_IDX;
                                st_d.stb = 1'b1;
                                st_d.addr = rtcia_pkg::IO_INDEX_ADDR;
                                st_d.we = 1'b1;
                                st_d.wdata = {1'b0, pwdata[6:0]};
                            end else begin
                                st_d.prdata = {25'h0000000, st_q.index};
                            end
                        end
                        rtcia_pkg::HOST_DATA_OFF: begin
                            st_d.wr = pwrite;
                            st_d.data = wbyte;
                            st_d.is_data = 1'b1;
                            if (pwrite && !listed && !st_q.allow) begin
                                st_d.err = 1'b1;
                            end else if (st_q.index <= rtcia_pkg::IDX_YEAR) begin
                                // Time registers wait until no update is running
                                st_d.state = HS_PIDX;
                                st_d.stb = 1'b1;
                                st_d.addr = rtcia_pkg::IO_INDEX_ADDR;
                                st_d.we = 1'b1;
                                st_d.wdata = {1'b0, rtcia_pkg::IDX_CTRL_A};
                            end else begin
                                st_d.state = HS_IDX;
                                st_d.stb = 1'b1;
                                st_d.addr = rtcia_pkg::IO_INDEX_ADDR;
                                st_d.we = 1'b1;
                                st_d.wdata = {1'b0, st_q.index};
                            end
                        end
                        rtcia_pkg::HOST_STAT_OFF: st_d.prdata = {31'h00000000, bus.irq};
                        rtcia_pkg::HOST_CTRL_OFF: begin
                            if (pwrite) begin
                                st_d.allow = pwdata[0];
                            end else begin
                                st_d.prdata = {31'h00000000, st_q.allow};
                            end
                        end
                        default: st_d.err = 1'b1;
                    endcase
                end
            end
            HS_PIDX: begin
                st_d.state = HS_PRD;
                st_d.stb = 1'b1;
                st_d.addr = rtcia_pkg::IO_DATA_ADDR;
                st_d.we = 1'b0;
            end
            HS_PRD: st_d.state = HS_PCHK;
            HS_PCHK: begin
                // Busy: poll again; idle: point the index back at the target
                st_d.state = bus.io_rdata[rtcia_pkg::A_UIP] ? HS_PIDX : HS_IDX;
                st_d.stb = 1'b1;
                st_d.addr = rtcia_pkg::IO_INDEX_ADDR;
                st_d.we = 1'b1;
                st_d.wdata = bus.io_rdata[rtcia_pkg::A_UIP]
                             ? {1'b0, rtcia_pkg::IDX_CTRL_A} : {1'b0, st_q.index};
            end
            HS_IDX: begin
                // Index always reloaded just before the data cycle
                if (st_q.is_data) begin
                    st_d.state = HS_DAT;
                    st_d.stb = 1'b1;
                    st_d.addr = rtcia_pkg::IO_DATA_ADDR;
                    st_d.we = st_q.wr;
                    st_d.wdata = st_q.data;
                end else begin
                    st_d.state = HS_DONE;
                end
            end
            HS_DAT: st_d.state = st_q.wr ? HS_DONE : HS_CAP;
            HS_CAP: begin
                st_d.prdata = {24'h000000, bus.io_rdata};
                st_d.state = HS_DONE;
            end
            HS_DONE: st_d.state = HS_IDLE;
            default: st_d.state = HS_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
            st_q.state <= HS_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign pready = (st_q.state == HS_DONE);
    assign pslverr = (st_q.state == HS_DONE) && st_q.err;
    assign prdata = st_q.prdata;
    assign irq_out = bus.irq;
    assign bus.io_stb = st_q.stb;
    assign bus.io_addr = st_q.addr;
    assign bus.io_we = st_q.we;
    assign bus.io_wdata = st_q.wdata;
endmodule : rtcia_host
`default_nettype wire

// File: rtcia_chk.sv
`timescale 1ns/10ps
`default_nettype none
// Watches the I/O link between the two ends
module rtcia_chk (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [15:0] io_addr,
    input wire logic io_stb,
    input wire logic io_we,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic irq
);
    logic [6:0] idx_q; // Index as last written
    wire logic ix_w = io_stb && io_we && io_addr == rtcia_pkg::IO_INDEX_ADDR;
    wire logic dr = io_stb && !io_we && io_addr == rtcia_pkg::IO_DATA_ADDR;
    wire logic c_rd = dr && idx_q == rtcia_pkg::IDX_FLAGS;
    // Track the index so data reads can be decoded
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            idx_q <= 7'h00;
        end else if (ix_w) begin
            idx_q <= io_wdata[6:0];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    AST_IDX_RANGE: assert property (ix_w |-> !io_wdata[7])
        else $error("index out of range");
    AST_PORTS: assert property (io_stb |-> io_addr inside {16'h0070, 16'h0071})
        else $error("cycle to unknown port");
    AST_IDX_FIRST: assert property (io_stb && io_addr == 16'h0071 |-> $past(ix_w))
        else $error("data cycle without index");
    AST_DIV: assert property (dr && idx_q == 7'h0a |=> io_rdata[6:4] == 3'h2)
        else $error("divider field wrong");
    AST_IRQ_FLAG: assert property (c_rd && irq |=> io_rdata[7])
        else $error("summary flag low with irq");
    AST_C_RSVD: assert property (c_rd |=> io_rdata[3:0] == 4'h0)
        else $error("reserved flag bits set");
    AST_VALID: assert property (dr && idx_q == 7'h0d |=> io_rdata[7:6] == 2'b10)
        else $error("valid bit wrong");
    AST_IRQ_HOLD: assert property (irq && !c_rd |=> irq)
        else $error("irq dropped early");
    cover property (c_rd && irq);
    cover property ($rose(irq));
    cover property (ix_w && io_wdata == 8'h0b);
endmodule : rtcia_chk
`default_nettype wire

// File: rtcia_bench.sv
`timescale 1ns/10ps
`default_nettype none
module rtcia_bench;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq_out, err;
    int err_count = 0;
    int tests_run = 0;
    rtcia_if bus_if();
    // Short second: 64 ticks of 4 cycles
    rtcia_dev #(.SEC_TICKS(64), .BASE_CYCLES(4)) rtcia_dev_i (.core_clk, .resetn, .bus(bus_if));
    rtcia_host rtcia_host_i (.core_clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .irq_out, .bus(bus_if));
    rtcia_chk rtcia_chk_i (.core_clk, .resetn, .io_addr(bus_if.io_addr), .io_stb(bus_if.io_stb),
        .io_we(bus_if.io_we), .io_wdata(bus_if.io_wdata), .io_rdata(bus_if.io_rdata),
        .irq(bus_if.irq));
    always #10 core_clk = ~core_clk;
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s exp %h seen %h", s, exp, seen);
        end
    endtask : chk
    // One APB transfer; waits for pready, no fixed latency assumed
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge core_clk) penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    // Index then data port access
    task automatic acc(input logic [6:0] i, input logic w, input logic [7:0] v);
        apb(12'h000, 1'b1, {25'h0, i});
        apb(12'h004, w, {24'h0, v});
    endtask : acc
    task automatic t_map;
        acc(7'h0a, 1'b0, 8'h0); chk("ctrl a", rd[7:0], 8'h20);
        acc(7'h0b, 1'b0, 8'h0); chk("ctrl b", rd[7:0], 8'h02);
        acc(7'h0d, 1'b1, 8'hff); acc(7'h0d, 1'b0, 8'h0); chk("valid", rd[7:0], 8'hbf);
        apb(12'h010, 1'b1, 32'h0); chk("unmapped", err, 1'b1);
        acc(7'h01, 1'b1, 8'h55); chk("unlisted", err, 1'b1);
        $display("map test done");
    endtask : t_map
    // Seconds wrap carries into minutes in the chosen format
    task automatic t_roll(input logic [7:0] b, input logic [7:0] s0, input logic [7:0] m1);
        int n = 0;
        acc(7'h0b, 1'b1, b); acc(7'h02, 1'b1, 8'h09); acc(7'h00, 1'b1, s0); acc(7'h0c, 1'b0, 0);
        while (irq_out !== 1'b1 && n < 600) begin
            @(posedge core_clk) n++;
        end
        chk("update irq", irq_out, 1'b1);
        acc(7'h00, 1'b0, 0); chk("seconds", rd[7:0], 8'h00);
        acc(7'h02, 1'b0, 0); chk("minutes", rd[7:0], m1);
        acc(7'h0c, 1'b0, 0); chk("flags", rd[7:4], 4'h9);
        chk("irq cleared", irq_out, 1'b0);
        $display("rollover test done");
    endtask : t_roll
    task automatic t_evt;
        acc(7'h0b, 1'b1, 8'h82); acc(7'h00, 1'b1, 8'h20);
        repeat (600) @(posedge core_clk);
        acc(7'h00, 1'b0, 0); chk("frozen", rd[7:0], 8'h20);
        acc(7'h0a, 1'b1, 8'h23); acc(7'h0b, 1'b1, 8'h02); acc(7'h0c, 1'b0, 0);
        repeat (40) @(posedge core_clk);
        acc(7'h0c, 1'b0, 0); chk("periodic flag", rd[7:6], 2'b01);
        acc(7'h0b, 1'b1, 8'h42);
        repeat (40) @(posedge core_clk);
        chk("periodic irq", irq_out, 1'b1);
        acc(7'h0a, 1'b1, 8'h20);
        $display("event test done");
    endtask : t_evt
    // Alarm with every field a wildcard fires at the next update
    task automatic t_alm;
        int n = 0;
        apb(12'h00c, 1'b1, 32'h1); apb(12'h00c, 1'b0, 32'h0);
        chk("allow", rd, 32'h1);
        acc(7'h01, 1'b1, 8'hc0); acc(7'h03, 1'b1, 8'hc0); acc(7'h05, 1'b1, 8'hc0);
        acc(7'h0d, 1'b1, 8'h00); acc(7'h0b, 1'b1, 8'h22); acc(7'h0c, 1'b0, 0);
        while (irq_out !== 1'b1 && n < 600) begin
            @(posedge core_clk) n++;
        end
        chk("alarm irq", irq_out, 1'b1);
        apb(12'h008, 1'b0, 32'h0); chk("stat irq", rd, 32'h1);
        acc(7'h0c, 1'b0, 0); chk("alarm flags", rd[7:4], 4'hb);
        $display("alarm test done");
    endtask : t_alm
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // Watchdog well beyond the expected run
    initial begin
        #800000;
        err_count++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        t_map();
        t_roll(8'h12, 8'h59, 8'h10);
        t_roll(8'h16, 8'h3b, 8'h0a);
        t_evt();
        t_alm();
        end_sim();
    end
endmodule : rtcia_bench
`default_nettype wire
